// ### common/fcp_pkg.sv
/*
 * fcp_pkg: register selects, command encodings, parameter slots, reset
 * values and timing counts of the floppy command parameter block.
 * assumes a 40 MHz reference clock and an eight-bit host bus.
 */
// Operation
// - register select 0 reaches controller status, 1 reaches command/result data.
// - host data bus is eight bits wide, bit 7 most significant.
// - cylinder parameter names the track, valid values 0 to 76.
// - format fills each sector with the write-pattern byte.
// - with size code 00 the short record length sets bytes per sector.
// - transfer ends after the sector numbered final sector on track.
// - gap three length sets byte times oscillator stays low after crc.
// - format uses gap three length as the written third gap.
// - head number 0 or 1 as recorded in the sector id field.
// - selected head picks head 0 or 1 and drives head select polarity.
// - head load delay spans 2 to 254 ms in 2 ms steps.
// - head unload delay spans 16 to 240 ms in 16 ms steps.
// - density select low picks fm, high picks mfm recording.
// - both sides continue: after side 0 ends, search sector 1 on side 1.
// - invalid command is a no-op, standby, first status byte 80.
package fcp_pkg;
  // host register selects
  localparam logic SEL_STATUS = 1'b0;
  localparam logic SEL_DATA   = 1'b1;
  // controller status bits
  localparam int MSR_RQM  = 7;
  localparam int MSR_DIO  = 6;
  localparam int MSR_EXM  = 5;
  localparam int MSR_BUSY = 4;
  // command word fields
  localparam int OP_MT  = 7;
  localparam int OP_MF  = 6;
  localparam int HD_BIT = 2;
  localparam logic [4:0] CMD_WRITE   = 5'h05;
  localparam logic [4:0] CMD_READ    = 5'h06;
  localparam logic [4:0] CMD_FORMAT  = 5'h0d;
  localparam logic [4:0] CMD_SPECIFY = 5'h03;
  // index of the last parameter byte per command
  localparam logic [2:0] LAST_RW   = 3'h7;
  localparam logic [2:0] LAST_FMT  = 3'h4;
  localparam logic [2:0] LAST_SPEC = 3'h1;
  // parameter slots
  localparam int P_SEL  = 0;
  localparam int P_CYL  = 1;
  localparam int P_HEAD = 2;
  localparam int P_REC  = 3;
  localparam int P_N    = 4;
  localparam int P_EOT  = 5;
  localparam int P_GPL  = 6;
  localparam int P_DTL  = 7;
  localparam int P_FN   = 1;
  localparam int P_FSC  = 2;
  localparam int P_FGPL = 3;
  localparam int P_FILL = 4;
  localparam int P_HUT  = 0;
  // limits and codes
  localparam logic [7:0]  CYL_MAX      = 8'h4c;
  localparam logic [7:0]  REC_FIRST    = 8'h01;
  localparam logic [15:0] SEC_BASE     = 16'h0080;
  localparam logic [7:0]  ST0_INVALID  = 8'h80;
  localparam logic [7:0]  ST0_ABNORMAL = 8'h40;
  localparam logic [7:0]  ST_CLEAR     = 8'h00;
  localparam logic [2:0]  RES_LAST     = 3'h6;
  localparam logic [2:0]  RES_LAST_INV = 3'h0;
  // reset values
  localparam logic [6:0] RST_HLT  = 7'h01;
  localparam logic [3:0] RST_HUT  = 4'h1;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // timing
  localparam int CLK_NS      = 25;
  localparam int MS_NS       = 1000000;
  localparam int HLT_STEP_MS = 2;
  localparam int HUT_STEP_MS = 16;
  localparam int BYTE_FM_NS  = 32000;
  localparam int BYTE_MFM_NS = 16000;
  localparam logic [15:0] BYTE_FM_CYC  = 16'((BYTE_FM_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] BYTE_MFM_CYC = 16'((BYTE_MFM_NS + CLK_NS - 1) / CLK_NS);
  // data path
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 4;
endpackage : fcp_pkg

// ### dv/fcp_drive_model.sv
/*
 * fcp_drive_model: behavioural drive far side, a read-stream source and
 * a write-stream sink that both stall one cycle in four.
 * assumes the bench clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module fcp_drive_model (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // read stream toward the device
  output logic            rx_valid_out,
  output logic      [7:0] rx_data_out,
  input  wire logic       rx_ready_in,
  // write stream from the device
  input  wire logic       tx_valid_in,
  input  wire logic [7:0] tx_data_in,
  output logic            tx_ready_out
);
  logic [7:0] idx_q;
  logic [1:0] ph_q;
  int         tx_cnt;
  logic [7:0] tx_mem [0:255];
  // stalls exercise fifo backpressure; idle data is inverted so it never looks stable
  assign rx_valid_out = (ph_q != 2'h3);
  assign rx_data_out  = rx_valid_out ? 8'h30 + idx_q : ~(8'h30 + idx_q);
  assign tx_ready_out = (ph_q != 2'h1);
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      idx_q  <= 8'h00;
      ph_q   <= 2'h0;
      tx_cnt <= 0;
    end else begin
      ph_q <= ph_q + 2'h1;
      if (rx_valid_out && rx_ready_in) idx_q <= idx_q + 8'h01;
      if (tx_valid_in && tx_ready_out) begin
        tx_mem[tx_cnt[7:0]] <= tx_data_in;
        tx_cnt              <= tx_cnt + 1;
      end
    end
  end
endmodule : fcp_drive_model

// ### dv/testbench.sv
/*
 * testbench: host-side command sequences for the floppy command block,
 * with a drive model on the streams.
 * assumes MS_CYC shortened to 20 cycles per millisecond.
 */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0, rst = 1'b1, sel = 1'b0, rd = 1'b0, wr = 1'b0;
  logic [7:0] din = 8'h00, dout, cyl, d, res [0:6];
  logic hsel, dens, hload, osc, gapw, oe, rxv, rxr, txv, txr, osc_seen = 1'b0;
  logic [7:0] rxd, txd;
  int err_total = 0, num_checks = 0, cyc = 0, gap_cnt = 0, base;
  always #12.5 clk = ~clk;
  fcp_top #(.MS_CYC(20)) dut (.ref_clk_in(clk), .sys_rst_in(rst),
    .register_select_line_in(sel), .host_rd_in(rd), .host_wr_in(wr),
    .host_data_bus_in(din), .host_data_bus_out(dout), .host_data_bus_oe_out(oe),
    .cylinder_out(cyl), .head_select_out(hsel), .density_select_out(dens),
    .head_load_out(hload), .phase_lock_oscillator_out(osc), .gap_write_out(gapw),
    .drive_rx_valid_in(rxv), .drive_rx_data_in(rxd), .drive_rx_ready_out(rxr),
    .drive_tx_valid_out(txv), .drive_tx_data_out(txd), .drive_tx_ready_in(txr));
  fcp_drive_model drv (.ref_clk_in(clk), .sys_rst_in(rst), .rx_valid_out(rxv),
    .rx_data_out(rxd), .rx_ready_in(rxr), .tx_valid_in(txv), .tx_data_in(txd),
    .tx_ready_out(txr));
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  // hang guard: the whole sequence needs well under 40000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (osc) osc_seen <= 1'b1;
    if (gapw) gap_cnt <= gap_cnt + 1;
    if (cyc == 60000) begin
      err_total++;
      summarize();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic host_wr(input logic s, input logic [7:0] b);
    @(posedge clk);
    #2 sel = s;
    din = b;
    wr = 1'b1;
    @(posedge clk);
    #2 wr = 1'b0;
  endtask : host_wr
  // read data is registered, so it is sampled just after the taking edge
  task automatic host_rd(input logic s, output logic [7:0] b);
    @(posedge clk);
    #2 sel = s;
    rd = 1'b1;
    @(posedge clk);
    #1 b = dout;
    chk("bus_oe", 8'h01, {7'h00, oe});
    #1 rd = 1'b0;
  endtask : host_rd
  task automatic cmd(input logic [7:0] b [$]);
    foreach (b[i]) host_wr(1'b1, b[i]);
  endtask : cmd
  task automatic wait_st(input logic [7:0] exp, input logic [7:0] msk);
    logic [7:0] s;
    int n;
    n = 0;
    do begin
      host_rd(1'b0, s);
      n++;
    end while ((s & msk) !== exp && n < 4000);
    if ((s & msk) !== exp) chk("status_wait", exp, s & msk);
  endtask : wait_st
  task automatic get_res();
    wait_st(8'hc0, 8'he0);
    for (int i = 0; i < 7; i++) host_rd(1'b1, res[i]);
  endtask : get_res
  initial begin
    repeat (3) @(posedge clk);
    #2 rst = 1'b0;
    host_rd(1'b0, d);
    chk("status_reset", 8'h80, d);
    cmd('{8'h1f});
    wait_st(8'hd0, 8'hf0);
    host_rd(1'b1, d);
    chk("st0_invalid", 8'h80, d);
    host_rd(1'b0, d);
    chk("status_idle", 8'h80, d);
    $display("test invalid done");
    cmd('{8'h03, 8'h01, 8'h02});
    base = drv.idx_q;
    cmd('{8'h46, 8'h04, 8'h4c, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h04});
    chk("cylinder", 8'h4c, cyl);
    chk("head_sel", 8'h01, {7'h00, hsel});
    chk("density", 8'h01, {7'h00, dens});
    chk("head_load", 8'h01, {7'h00, hload});
    for (int i = 0; i < 4; i++) begin
      wait_st(8'he0, 8'he0);
      host_rd(1'b1, d);
      chk("read_byte", 8'h30 + 8'(base + i), d);
    end
    get_res();
    chk("rd_st0", 8'h04, res[0]);
    chk("rd_cyl", 8'h4c, res[3]);
    chk("rd_head", 8'h01, res[4]);
    chk("rd_size", 8'h00, res[6]);
    chk("osc_active", 8'h01, {7'h00, osc_seen});
    $display("test read done");
    cmd('{8'h46, 8'h04, 8'h4d, 8'h01, 8'h01, 8'h00, 8'h01, 8'h01, 8'h04});
    get_res();
    chk("bad_cyl_st0", 8'h44, res[0]);
    $display("test cylinder limit done");
    base = drv.tx_cnt;
    cmd('{8'h85, 8'h00, 8'h02, 8'h00, 8'h01, 8'h00, 8'h01, 8'h01, 8'h02});
    chk("density_fm", 8'h00, {7'h00, dens});
    for (int i = 0; i < 4; i++) begin
      wait_st(8'ha0, 8'he0);
      host_wr(1'b1, 8'hc0 + 8'(i));
    end
    get_res();
    chk("mt_head", 8'h01, res[4]);
    chk("mt_head_sel", 8'h01, {7'h00, hsel});
    chk("mt_count", 8'h04, 8'(drv.tx_cnt - base));
    for (int i = 0; i < 4; i++) chk("wr_byte", 8'hc0 + 8'(i), drv.tx_mem[8'(base + i)]);
    $display("test multi-track write done");
    gap_cnt = 0;
    cmd('{8'h0d, 8'h00, 8'h00, 8'h01, 8'h01, 8'ha5});
    get_res();
    chk("fill_byte", 8'ha5, drv.tx_mem[8'(drv.tx_cnt - 1)]);
    chk("gap_len_lo", 8'h00, gap_cnt[7:0]);
    chk("gap_len_hi", 8'h05, gap_cnt[15:8]);
    $display("test format done");
    summarize();
  end
endmodule : testbench

// ### logic/fcp_fifo.sv
/*
 * fcp_fifo: small flip-flop fifo with valid/ready on both sides.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module fcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             sys_rst_in,
  // fill side
  input  wire logic             wr_valid_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  output logic                  wr_ready_out,
  // drain side
  output logic                  rd_valid_out,
  output logic      [WIDTH-1:0] rd_data_out,
  input  wire logic             rd_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  wire              push = wr_valid_in && wr_ready_out;
  wire              pop  = rd_valid_out && rd_ready_in;

  // ready is honest: full blocks the source until the drain moves
  assign wr_ready_out = cnt_q != (AW+1)'(DEPTH);
  assign rd_valid_out = cnt_q != '0;
  assign rd_data_out  = mem_q[rp_q];

  genvar i;
  for (i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) mem_q[i] <= '0;
      else if (push && wp_q == AW'(i)) mem_q[i] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= (wp_q == AW'(DEPTH - 1)) ? '0 : wp_q + 1'b1;
      if (pop) rp_q <= (rp_q == AW'(DEPTH - 1)) ? '0 : rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : fcp_fifo

// ### logic/fcp_top.sv
/*
 * fcp_top: command parameter interpreter of a floppy controller. the host
 * writes command words and reads status and results; sector data passes a
 * small fifo between host and drive streams.
 * assumes host strobes synchronous to ref_clk_in, one cycle each.
 */
`timescale 1ns/1ps
module fcp_top #(
  parameter int unsigned MS_CYC = fcp_pkg::MS_NS / fcp_pkg::CLK_NS
) (
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // host bus
  input  wire logic       register_select_line_in,
  input  wire logic       host_rd_in,
  input  wire logic       host_wr_in,
  input  wire logic [7:0] host_data_bus_in,
  output logic      [7:0] host_data_bus_out,
  output logic            host_data_bus_oe_out,
  // drive control
  output logic      [7:0] cylinder_out,
  output logic            head_select_out,
  output logic            density_select_out,
  output logic            head_load_out,
  output logic            phase_lock_oscillator_out,
  output logic            gap_write_out,
  // drive read stream
  input  wire logic       drive_rx_valid_in,
  input  wire logic [7:0] drive_rx_data_in,
  output logic            drive_rx_ready_out,
  // drive write stream
  output logic            drive_tx_valid_out,
  output logic      [7:0] drive_tx_data_out,
  input  wire logic       drive_tx_ready_in
);
  typedef enum logic [2:0] {
    S_IDLE, S_PARAM, S_LOAD, S_XFER, S_GAP, S_DRAIN, S_RESULT
  } fcp_state_t;

  fcp_state_t state_q;
  fcp_state_t state_d;
  logic [7:0]  op_q;
  logic [7:0]  p_q [8];
  logic [2:0]  p_idx_q;
  logic [2:0]  p_last_q;
  logic [2:0]  res_idx_q;
  logic        inv_q;
  logic        abn_q;
  logic        last_q;
  logic [7:0]  cyl_q;
  logic [7:0]  rec_q;
  logic        head_q;
  logic        hd_q;
  logic [6:0]  hlt_q;
  logic [3:0]  hut_q;
  logic        loaded_q;
  logic [15:0] byte_q;
  logic [15:0] pre_q;
  logic [7:0]  cnt_q;
  logic [7:0]  out_q;
  logic [15:0] host_cnt_q;

  // host strobe decode
  wire host_wr_dr = host_wr_in && register_select_line_in == fcp_pkg::SEL_DATA;
  wire host_rd_dr = host_rd_in && register_select_line_in == fcp_pkg::SEL_DATA;

  // opcode decode
  wire [4:0] code_in = host_data_bus_in[4:0];
  wire       in_rw   = code_in == fcp_pkg::CMD_READ || code_in == fcp_pkg::CMD_WRITE;
  wire       in_fmt  = code_in == fcp_pkg::CMD_FORMAT;
  wire       in_spec = code_in == fcp_pkg::CMD_SPECIFY;
  wire       in_inv  = !(in_rw || in_fmt || in_spec);
  wire [2:0] last_in = in_rw ? fcp_pkg::LAST_RW :
                       in_fmt ? fcp_pkg::LAST_FMT : fcp_pkg::LAST_SPEC;
  wire [4:0] code_q  = op_q[4:0];
  wire       is_rd   = code_q == fcp_pkg::CMD_READ;
  wire       is_wr   = code_q == fcp_pkg::CMD_WRITE;
  wire       is_fmt  = code_q == fcp_pkg::CMD_FORMAT;
  wire       is_spec = code_q == fcp_pkg::CMD_SPECIFY;
  wire       mt_w    = op_q[fcp_pkg::OP_MT];

  // parameter fields; format packs a shorter list
  wire [7:0]  n_w    = is_fmt ? p_q[fcp_pkg::P_FN] : p_q[fcp_pkg::P_N];
  wire [7:0]  eot_w  = is_fmt ? p_q[fcp_pkg::P_FSC] : p_q[fcp_pkg::P_EOT];
  wire [7:0]  gpl_w  = is_fmt ? p_q[fcp_pkg::P_FGPL] : p_q[fcp_pkg::P_GPL];
  wire [7:0]  fill_w = p_q[fcp_pkg::P_FILL];
  wire [1:0]  us_w   = p_q[fcp_pkg::P_SEL][1:0];
  wire        hd_w   = p_q[fcp_pkg::P_SEL][fcp_pkg::HD_BIT];
  wire        bad_cyl = !is_fmt && p_q[fcp_pkg::P_CYL] > fcp_pkg::CYL_MAX;
  // size codes above 7 wrap; only 0..7 are meaningful sector sizes
  wire [15:0] sec_size = (n_w == 8'h00) ? {8'h00, p_q[fcp_pkg::P_DTL]}
                                        : fcp_pkg::SEC_BASE << n_w[2:0];
  wire [7:0]  hlt_ms = 8'(hlt_q * fcp_pkg::HLT_STEP_MS);
  wire [7:0]  hut_ms = 8'(hut_q * fcp_pkg::HUT_STEP_MS);
  wire [15:0] byte_cyc = op_q[fcp_pkg::OP_MF] ? fcp_pkg::BYTE_MFM_CYC
                                              : fcp_pkg::BYTE_FM_CYC;

  // state groups
  wire st_exec = state_q == S_LOAD || state_q == S_XFER ||
                 state_q == S_GAP || state_q == S_DRAIN;
  wire st_xfer = state_q == S_XFER;

  // fifo wiring: direction follows the command
  wire       f_in_valid;
  wire [7:0] f_in_data;
  wire       f_in_ready;
  wire       f_out_valid;
  wire [7:0] f_out_data;
  wire       f_out_ready;
  wire       wr_room = host_cnt_q < sec_size;
  assign f_in_valid  = st_xfer && (is_rd ? drive_rx_valid_in :
                                   is_wr ? (host_wr_dr && wr_room) : is_fmt);
  assign f_in_data   = is_rd ? drive_rx_data_in : is_wr ? host_data_bus_in : fill_w;
  assign f_out_ready = is_rd ? (host_rd_dr && st_exec) : drive_tx_ready_in;
  wire   push_w      = f_in_valid && f_in_ready;
  wire   pop_w       = f_out_valid && f_out_ready;

  fcp_fifo #(
    .WIDTH (fcp_pkg::DATA_W),
    .DEPTH (fcp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in   (ref_clk_in),
    .sys_rst_in   (sys_rst_in),
    .wr_valid_in  (f_in_valid),
    .wr_data_in   (f_in_data),
    .wr_ready_out (f_in_ready),
    .rd_valid_out (f_out_valid),
    .rd_data_out  (f_out_data),
    .rd_ready_in  (f_out_ready)
  );

  // sector accounting: writes count bytes handed to the drive
  wire beat_w   = is_wr ? (pop_w && st_xfer) : push_w;
  wire sec_done = beat_w && byte_q == sec_size - 16'h0001;
  wire side_sw  = rec_q == eot_w && mt_w && !head_q && !is_fmt;
  wire last_sec = rec_q == eot_w && !side_sw;

  // shared timer: ms ticks for head delays, byte ticks in the gap
  wire [15:0] pre_lim = (state_q == S_GAP) ? byte_cyc : 16'(MS_CYC);
  wire        tick    = pre_q == pre_lim - 16'h0001;
  wire        gap_end = gpl_w == 8'h00 || (tick && cnt_q == gpl_w - 8'h01);
  wire        restart = state_d != state_q &&
                        (state_d == S_LOAD || state_d == S_GAP || state_q == S_GAP);
  wire        unload  = loaded_q && !st_exec && cnt_q >= hut_ms;

  // controller status and result bytes
  wire rqm = state_q == S_IDLE || state_q == S_PARAM || state_q == S_RESULT ||
             (st_exec && is_rd && f_out_valid) ||
             (st_xfer && is_wr && f_in_ready && wr_room);
  wire dio = state_q == S_RESULT || (st_exec && is_rd);
  wire [7:0] msr = {rqm, dio, st_exec, state_q != S_IDLE, 4'h0};
  wire [7:0] st0 = inv_q ? fcp_pkg::ST0_INVALID :
                   ((abn_q ? fcp_pkg::ST0_ABNORMAL : fcp_pkg::ST_CLEAR) |
                    {5'h00, head_q, us_w});
  wire [2:0] res_last = inv_q ? fcp_pkg::RES_LAST_INV : fcp_pkg::RES_LAST;
  wire [7:0] res_w [7];
  assign res_w[0] = st0;
  assign res_w[1] = fcp_pkg::ST_CLEAR;
  assign res_w[2] = fcp_pkg::ST_CLEAR;
  assign res_w[3] = cyl_q;
  assign res_w[4] = {7'h00, head_q};
  assign res_w[5] = rec_q;
  assign res_w[6] = n_w;
  wire [7:0] dr_w = (state_q == S_RESULT) ? res_w[res_idx_q] : f_out_data;
  wire [7:0] out_d = (register_select_line_in == fcp_pkg::SEL_STATUS) ? msr : dr_w;

  always_comb begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (host_wr_dr) state_d = in_inv ? S_RESULT : S_PARAM;
      end
      S_PARAM: begin
        if (host_wr_dr && p_idx_q == p_last_q) begin
          state_d = is_spec ? S_IDLE : bad_cyl ? S_RESULT : S_LOAD;
        end
      end
      S_LOAD: begin
        if (loaded_q || cnt_q >= hlt_ms) state_d = S_XFER;
      end
      S_XFER: begin
        if (sec_done) state_d = S_GAP;
      end
      S_GAP: begin
        if (gap_end) state_d = last_q ? S_DRAIN : S_XFER;
      end
      S_DRAIN: begin
        if (!f_out_valid) state_d = S_RESULT;
      end
      S_RESULT: begin
        if (host_rd_dr && res_idx_q == res_last) state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
  end

  // parameter bytes, one slot each
  genvar gi;
  for (gi = 0; gi < 8; gi++) begin : g_par
    always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) p_q[gi] <= fcp_pkg::RST_BYTE;
      else if (state_q == S_PARAM && host_wr_dr && p_idx_q == 3'(gi)) p_q[gi] <= host_data_bus_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_q   <= S_IDLE;
      op_q      <= fcp_pkg::RST_BYTE;
      p_idx_q   <= '0;
      p_last_q  <= '0;
      res_idx_q <= '0;
      inv_q     <= 1'b0;
      abn_q     <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == S_IDLE && host_wr_dr) begin
        op_q     <= host_data_bus_in;
        inv_q    <= in_inv;
        abn_q    <= 1'b0;
        p_idx_q  <= '0;
        p_last_q <= last_in;
      end
      if (state_q == S_PARAM && host_wr_dr) begin
        p_idx_q <= p_idx_q + 3'h1;
        if (p_idx_q == p_last_q) abn_q <= bad_cyl;
      end
      if (state_q != S_RESULT) res_idx_q <= '0;
      else if (host_rd_dr) res_idx_q <= res_idx_q + 3'h1;
    end
  end

  // head, cylinder and sector position
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cyl_q  <= fcp_pkg::RST_BYTE;
      rec_q  <= fcp_pkg::RST_BYTE;
      head_q <= 1'b0;
      hd_q   <= 1'b0;
      hlt_q  <= fcp_pkg::RST_HLT;
      hut_q  <= fcp_pkg::RST_HUT;
      byte_q <= '0;
      last_q <= 1'b0;
    end else begin
      if (state_q == S_PARAM && host_wr_dr && p_idx_q == p_last_q) begin
        if (is_spec) begin
          hut_q <= p_q[fcp_pkg::P_HUT][3:0];
          hlt_q <= host_data_bus_in[7:1];
        end else begin
          hd_q   <= hd_w;
          head_q <= is_fmt ? hd_w : p_q[fcp_pkg::P_HEAD][0];
          rec_q  <= is_fmt ? fcp_pkg::REC_FIRST : p_q[fcp_pkg::P_REC];
          if (!is_fmt) cyl_q <= p_q[fcp_pkg::P_CYL];
        end
        byte_q <= '0;
        last_q <= 1'b0;
      end else if (sec_done) begin
        byte_q <= '0;
        last_q <= last_sec;
        if (side_sw) begin
          head_q <= 1'b1;
          hd_q   <= 1'b1;
          rec_q  <= fcp_pkg::REC_FIRST;
        end else if (!last_sec) begin
          rec_q <= rec_q + 8'h01;
        end
      end else if (beat_w) begin
        byte_q <= byte_q + 16'h0001;
      end
    end
  end

  // delay timer and head load state
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pre_q    <= '0;
      cnt_q    <= '0;
      loaded_q <= 1'b0;
    end else begin
      if (restart || tick) pre_q <= '0;
      else pre_q <= pre_q + 16'h0001;
      if (restart) cnt_q <= '0;
      else if (tick && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
      if (state_q == S_LOAD && state_d == S_XFER) loaded_q <= 1'b1;
      else if (unload) loaded_q <= 1'b0;
    end
  end

  // host bytes taken this sector; rqm must not promise room the sector lacks
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) host_cnt_q <= '0;
    else if (sec_done || state_q == S_PARAM) host_cnt_q <= '0;
    else if (push_w && is_wr) host_cnt_q <= host_cnt_q + 16'h0001;
  end

  // registered read data; a new command reloads the head only if unloaded
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) out_q <= fcp_pkg::RST_BYTE;
    else out_q <= out_d;
  end

  assign host_data_bus_out         = out_q;
  assign host_data_bus_oe_out      = host_rd_in;
  assign cylinder_out              = cyl_q;
  assign head_select_out           = hd_q;
  assign density_select_out        = op_q[fcp_pkg::OP_MF];
  assign head_load_out             = loaded_q || state_q == S_LOAD;
  assign phase_lock_oscillator_out = st_xfer;
  assign gap_write_out             = state_q == S_GAP && is_fmt;
  assign drive_rx_ready_out        = st_xfer && is_rd && f_in_ready;
  assign drive_tx_valid_out        = f_out_valid && !is_rd;
  assign drive_tx_data_out         = f_out_data;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  status_route_a: assert property (
    $past(state_q) == S_RESULT && $past(register_select_line_in) == fcp_pkg::SEL_STATUS
    |-> host_data_bus_out[7:6] == 2'b11)
    else $error("status read in result phase lacks rqm and dio");
  cyl_range_a: assert property (
    st_xfer && !is_fmt |-> cyl_q <= fcp_pkg::CYL_MAX)
    else $error("transfer started on cylinder above 76");
  fill_byte_a: assert property (
    drive_tx_valid_out && is_fmt |-> drive_tx_data_out == fill_w)
    else $error("format byte differs from write pattern");
  short_len_a: assert property (
    beat_w && st_xfer && n_w == 8'h00 |-> byte_q < {8'h00, p_q[fcp_pkg::P_DTL]})
    else $error("short record overran its length");
  eot_stop_a: assert property (
    sec_done && last_sec |=> state_q == S_GAP && last_q ##[1:1000] state_q != S_XFER)
    else $error("transfer continued past final sector");
  gap_low_a: assert property (
    state_q == S_GAP |-> !phase_lock_oscillator_out && cnt_q <= gpl_w)
    else $error("oscillator high or gap overran its length");
  fmt_gap_a: assert property (
    $rose(state_q == S_GAP) && is_fmt |-> gap_write_out [*2])
    else $error("format gap not written");
  head_sel_a: assert property (
    $rose(state_q == S_LOAD) |-> head_select_out == p_q[fcp_pkg::P_SEL][fcp_pkg::HD_BIT])
    else $error("head select does not follow selected head");
  load_wait_a: assert property (
    state_q == S_LOAD && !loaded_q |-> cnt_q <= hlt_ms)
    else $error("head load wait overran its setting");
  unload_time_a: assert property (
    $fell(loaded_q) |-> $past(cnt_q) >= hut_ms)
    else $error("head unloaded too early");
  side_cont_a: assert property (
    sec_done && side_sw |=> head_q && rec_q == fcp_pkg::REC_FIRST && state_q == S_GAP)
    else $error("no continuation to sector 1 on side 1");
  invalid_cmd_a: assert property (
    state_q == S_IDLE && host_wr_dr && in_inv
    |=> state_q == S_RESULT ##1
        ($past(register_select_line_in) == fcp_pkg::SEL_STATUS ||
         host_data_bus_out == fcp_pkg::ST0_INVALID))
    else $error("invalid command did not report status 80");

  read_done_c: cover property (st_exec && is_rd ##[1:1000] state_q == S_RESULT);
  side_sw_c: cover property (sec_done && side_sw);
  invalid_c: cover property (state_q == S_IDLE && host_wr_dr && in_inv);
  fmt_gap_c: cover property (state_q == S_GAP && is_fmt);
endmodule : fcp_top
